// >>> rscd_clkgen_model.sv
`timescale 1ns/1ns
// Clock generator stand-in: restarts on every load, slow or prompt
module rscd_clkgen_model #(
    parameter int DLY = 4
)(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Load request in, running report out
    input  wire logic clk_load,
    output logic      clk_ready
);
    int cnt_r;

    // A reload stops the oscillator; it needs DLY+1 cycles to start again
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_r     <= 0;
            clk_ready <= 1'b0;
        end
        else if (clk_load)
        begin
            cnt_r     <= 0;
            clk_ready <= 1'b0;
        end
        else if (cnt_r < DLY)
            cnt_r <= cnt_r + 1;
        else
            clk_ready <= 1'b1;
    end
endmodule // rscd_clkgen_model

// >>> rscd_pkg.sv
package rscd_pkg;

    // Clock source selection toward the clock generator
    typedef enum logic [1:0] {
        rscd_src_pll_selfosc,
        rscd_src_int_osc_half,
        rscd_src_other
    } rscd_src_t;

    // Default clock settings carried as one group
    typedef struct packed {
        rscd_src_t  src;
        logic [7:0] base_div;
        logic [7:0] cpu_div;
        logic [7:0] pbus_div;
    } rscd_clk_cfg_t;

    // Latched cause of the last reset
    typedef struct packed {
        logic pin;
        logic sw;
        logic wdt;
        logic lowv;
        logic osc_stop;
    } rscd_cause_t;

    typedef enum logic [1:0] {
        rscd_st_reset,
        rscd_st_wait_clk,
        rscd_st_settle,
        rscd_st_run
    } rscd_state_t;

endpackage

// >>> rscd_regs.svh
`ifndef RSCD_REGS_SVH
`define RSCD_REGS_SVH

// Default divider ratios applied after any reset
`define RSCD_NEW_BASE_DIV      8'h06
`define RSCD_NEW_CPU_DIV       8'h0c
`define RSCD_NEW_PBUS_DIV      8'h0c
`define RSCD_OLD_CPU_DIV       8'h10
`define RSCD_OLD_PBUS_DIV      8'h10
`define RSCD_OLD_BASE_DIV      8'h01

// Reset values of the preserved-capable registers
`define RSCD_PM_RST            8'h00
`define RSCD_VDA_RST           8'h00
`define RSCD_VDB_RST           8'h00
`define RSCD_OSC_RST           8'h00
// Bits of the oscillation stop control kept over an osc-stop reset
`define RSCD_OSC_KEEP_MASK     8'h83

// Clock settle time before reset release, in ns
`define RSCD_SETTLE_NS         200
`define RSCD_CLK_NS            10
`define RSCD_SETTLE_CYC ((`RSCD_SETTLE_NS + `RSCD_CLK_NS - 1) / `RSCD_CLK_NS)

`endif

// >>> rscd_top.sv
`timescale 1ns/1ns
`include "rscd_regs.svh"
// Operation
// R01 - Pin, software or watchdog reset resets the chip, and on the legacy variant low supply also does.
// R02 - Only the legacy variant resets on oscillation stop detection.
// R03 - On the newer variant software and watchdog resets keep the processor mode register.
// R04 - On the legacy variant both voltage detect registers survive software, watchdog and osc-stop resets.
// R05 - On the legacy variant an osc-stop reset keeps bits 7, 1 and 0 of the osc stop control register.
// R06 - The newer variant restarts on the PLL in self-oscillation mode.
// R07 - The legacy variant restarts on the half-rate internal oscillator clock.
// R08 - Newer variant divides base by 6 and CPU/bus by 12; legacy divides CPU/peripheral by 16.
// R09 - Core reset is held until the default clock runs with its dividers applied.
module rscd_top
    import rscd_pkg::*;
#(
    parameter bit LEGACY = 1'b1
)(
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst,
    // Reset source pins and requests
    input  wire logic          reset_pin_n,
    input  wire logic          lowv_det,
    input  wire logic          osc_stop_det,
    input  wire logic          sw_reset_req,
    input  wire logic          wdt_timeout,
    // Register writes from the core
    input  wire logic          pm_we,
    input  wire logic          vda_we,
    input  wire logic          vdb_we,
    input  wire logic          osc_we,
    input  wire logic [7:0]    wdata,
    // Clock generator handshake
    input  wire logic          clk_ready,
    output rscd_clk_cfg_t      clk_cfg,
    output logic               clk_load,
    // Reset outputs and register contents
    output logic               core_rst,
    output rscd_cause_t        cause,
    output logic [7:0]         processor_mode_reg,
    output logic [7:0]         voltage_detect_ctrl_a,
    output logic [7:0]         voltage_detect_ctrl_b,
    output logic [7:0]         osc_stop_detect_ctrl
);

    localparam int SETTLE = `RSCD_SETTLE_CYC;

    // The settle counter is 16 bits wide and needs at least one cycle
    if (SETTLE < 1 || SETTLE > 65535)
    begin : g_bad_settle
        $error("settle count does not fit the settle counter");
    end

    // Pins come from outside the clock domain: two flops each
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sync1_r <= 3'h1;
            sync2_r <= 3'h1;
        end
        else
        begin
            sync1_r <= {osc_stop_det, lowv_det, reset_pin_n};
            sync2_r <= sync1_r;
        end
    end

    // Source qualification per variant
    logic ev_pin, ev_sw, ev_wdt, ev_lowv, ev_osc, ev_any;
    assign ev_pin  = ~sync2_r[0];                 // R01
    assign ev_sw   = sw_reset_req;                // R01
    assign ev_wdt  = wdt_timeout;                 // R01
    assign ev_lowv = LEGACY & sync2_r[1];         // R01
    assign ev_osc  = LEGACY & sync2_r[2];         // R02
    assign ev_any  = ev_pin | ev_sw | ev_wdt | ev_lowv | ev_osc;

    // Default clock setting for this variant
    function automatic rscd_clk_cfg_t dflt_cfg();
        rscd_clk_cfg_t c;
        if (LEGACY)
        begin
            c.src      = rscd_src_int_osc_half;   // R07
            c.base_div = `RSCD_OLD_BASE_DIV;
            c.cpu_div  = `RSCD_OLD_CPU_DIV;       // R08
            c.pbus_div = `RSCD_OLD_PBUS_DIV;      // R08
        end
        else
        begin
            c.src      = rscd_src_pll_selfosc;    // R06
            c.base_div = `RSCD_NEW_BASE_DIV;      // R08
            c.cpu_div  = `RSCD_NEW_CPU_DIV;       // R08
            c.pbus_div = `RSCD_NEW_PBUS_DIV;      // R08
        end
        return c;
    endfunction

    // Sequencer: restart whenever a source fires, release after clock settle
    rscd_state_t state_r;
    logic [15:0] cnt_r;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r <= rscd_st_reset;
            cnt_r   <= 16'h0000;
        end
        else if (ev_any)
        begin
            state_r <= rscd_st_reset;
            cnt_r   <= 16'h0000;
        end
        else
        begin
            case (state_r)
                rscd_st_reset:
                    state_r <= rscd_st_wait_clk;
                rscd_st_wait_clk:
                    if (clk_ready)
                    begin
                        state_r <= rscd_st_settle;  // R09
                        cnt_r   <= 16'h0000;
                    end
                rscd_st_settle:
                    if (!clk_ready)
                        state_r <= rscd_st_wait_clk;
                    else if (cnt_r == 16'(SETTLE - 1))
                        state_r <= rscd_st_run;     // R09
                    else
                        cnt_r <= cnt_r + 16'h0001;
                default:
                    state_r <= rscd_st_run;
            endcase
        end
    end

    // Outputs toward the clock generator and core
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            core_rst <= 1'b1;
            clk_load <= 1'b1;
            clk_cfg  <= '0;
        end
        else
        begin
            core_rst <= ev_any || (state_r != rscd_st_run);  // R09
            clk_load <= ev_any || state_r == rscd_st_reset;
            if (ev_any || state_r == rscd_st_reset)
                clk_cfg <= dflt_cfg();
        end
    end

    // Cause latch: a new reset replaces the last cause
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cause <= '0;
        else if (ev_any)
            cause <= '{pin: ev_pin, sw: ev_sw, wdt: ev_wdt,
                       lowv: ev_lowv, osc_stop: ev_osc};
    end

    // Retention classes; pin reset and low supply clear everything
    logic hard_ev, keep_pm, keep_vd;
    assign hard_ev = ev_pin | ev_lowv;
    assign keep_pm = !LEGACY && !hard_ev;                // R03
    assign keep_vd = LEGACY && !hard_ev;                 // R04

    // Processor mode register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            processor_mode_reg <= `RSCD_PM_RST;
        else if (ev_any && !keep_pm)
            processor_mode_reg <= `RSCD_PM_RST;          // R03
        else if (!ev_any && pm_we && !core_rst)
            processor_mode_reg <= wdata;
    end

    // Voltage detect control registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            voltage_detect_ctrl_a <= `RSCD_VDA_RST;
            voltage_detect_ctrl_b <= `RSCD_VDB_RST;
        end
        else if (ev_any && !keep_vd)
        begin
            voltage_detect_ctrl_a <= `RSCD_VDA_RST;      // R04
            voltage_detect_ctrl_b <= `RSCD_VDB_RST;      // R04
        end
        else if (!ev_any && !core_rst)
        begin
            if (vda_we)
                voltage_detect_ctrl_a <= wdata;
            if (vdb_we)
                voltage_detect_ctrl_b <= wdata;
        end
    end

    // Osc stop control: an osc-stop-only reset keeps the masked bits
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            osc_stop_detect_ctrl <= `RSCD_OSC_RST;
        else if (ev_any && ev_osc && !(ev_pin | ev_lowv | ev_sw | ev_wdt))
            osc_stop_detect_ctrl <= (osc_stop_detect_ctrl
                                     & `RSCD_OSC_KEEP_MASK)
                                    | (`RSCD_OSC_RST
                                       & ~`RSCD_OSC_KEEP_MASK);  // R05
        else if (ev_any)
            osc_stop_detect_ctrl <= `RSCD_OSC_RST;
        else if (osc_we && !core_rst)
            osc_stop_detect_ctrl <= wdata;
    end

    // Checks
    a_core_held: assert property (@(posedge clk_sys) disable iff (rst)
        ev_any |=> core_rst)
        else $error("core reset not asserted after source"); // R01
    a_no_osc_new: assert property (@(posedge clk_sys) disable iff (rst)
        (!LEGACY && sync2_r[2] && !ev_pin && !ev_sw && !ev_wdt)
        |-> !ev_any)
        else $error("osc stop reset on newer variant"); // R02
    a_pm_kept: assert property (@(posedge clk_sys) disable iff (rst)
        (!LEGACY && (ev_sw || ev_wdt) && !hard_ev)
        |=> processor_mode_reg == $past(processor_mode_reg))
        else $error("mode register lost on soft reset"); // R03
    a_vd_kept: assert property (@(posedge clk_sys) disable iff (rst)
        (LEGACY && ev_any && !hard_ev)
        |=> voltage_detect_ctrl_a == $past(voltage_detect_ctrl_a))
        else $error("voltage detect register lost"); // R04
    a_osc_bits: assert property (@(posedge clk_sys) disable iff (rst)
        (LEGACY && ev_osc && !hard_ev && !ev_sw && !ev_wdt)
        |=> (osc_stop_detect_ctrl & 8'h83)
            == ($past(osc_stop_detect_ctrl) & 8'h83))
        else $error("osc stop bits not kept"); // R05
    a_src_new: assert property (@(posedge clk_sys) disable iff (rst)
        (!LEGACY && ev_any) |=> clk_cfg.src == rscd_src_pll_selfosc)
        else $error("newer variant clock source wrong"); // R06
    a_src_old: assert property (@(posedge clk_sys) disable iff (rst)
        (LEGACY && ev_any) |=> clk_cfg.src == rscd_src_int_osc_half)
        else $error("legacy clock source wrong"); // R07
    a_div_dflt: assert property (@(posedge clk_sys) disable iff (rst)
        ev_any |=> clk_cfg.cpu_div == (LEGACY ? 8'h10 : 8'h0c)
                   && clk_cfg.pbus_div == (LEGACY ? 8'h10 : 8'h0c))
        else $error("default dividers wrong"); // R08
    a_release: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(core_rst) |-> clk_ready && $past(clk_ready))
        else $error("reset released without clock"); // R09

endmodule // rscd_top

// >>> rscd_top_bench.sv
`timescale 1ns/1ns
module rscd_top_bench;
    import rscd_pkg::*;
    logic clk_sys = 0, rst = 1, pin_n = 1, lowv = 0, oscs = 0;
    logic sw = 0, wdt = 0;
    logic [3:0] we = 4'h0;
    logic [7:0] wd = 8'h00;
    logic [1:0] rdy, load, crst;
    rscd_clk_cfg_t cfg [2];
    rscd_cause_t cs [2];
    logic [7:0] pm [2], va [2], vb [2], oc [2];
    logic [7:0] v [4];
    logic [4:0] cexp [5] = '{5'h08, 5'h04, 5'h01, 5'h02, 5'h10};
    int miscompares = 0, cmp_count = 0;

    always #5 clk_sys = ~clk_sys;

    // Instance 0 is the legacy variant with a slow clock, 1 the newer one
    for (genvar g = 0; g < 2; g++)
    begin : v_g
        rscd_top #(.LEGACY(g == 0)) uut (
            .clk_sys(clk_sys), .rst(rst), .reset_pin_n(pin_n),
            .lowv_det(lowv), .osc_stop_det(oscs), .sw_reset_req(sw),
            .wdt_timeout(wdt), .pm_we(we[0]), .vda_we(we[1]),
            .vdb_we(we[2]), .osc_we(we[3]), .wdata(wd),
            .clk_ready(rdy[g]), .clk_cfg(cfg[g]), .clk_load(load[g]),
            .core_rst(crst[g]), .cause(cs[g]), .processor_mode_reg(pm[g]),
            .voltage_detect_ctrl_a(va[g]), .voltage_detect_ctrl_b(vb[g]),
            .osc_stop_detect_ctrl(oc[g]));
        rscd_clkgen_model #(.DLY(g ? 1 : 15)) cg (.clk_sys(clk_sys),
            .rst(rst), .clk_load(load[g]), .clk_ready(rdy[g]));
    end

    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask

    // Expected content of a register that a reset either keeps or clears
    function automatic logic [7:0] kept(input bit keep,
                                        input logic [7:0] val);
        return keep ? val : 8'h00;
    endfunction

    task close_out;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Wait for release, counting cycles with the clock reported running
    task automatic settle(input int g, input bit en);
        int n, r;
        n = 0;
        r = 0;
        if (!en)
            return;
        while (crst[g] !== 1'b0)
        begin
            @(posedge clk_sys);
            #1;
            n++;
            if (rdy[g] === 1'b1)
                r++;
            if (n > 300)
            begin
                chk("timeout", 0, 1);
                close_out;
            end
        end
        chk("settle", r >= 20, 1);
        chk("src", cfg[g].src,
            g ? rscd_src_pll_selfosc : rscd_src_int_osc_half);
        chk("div", {cfg[g].cpu_div, cfg[g].pbus_div},
            g ? 16'h0c0c : 16'h1010);
        chk("base", cfg[g].base_div, g ? 8'h06 : 8'h01);
        chk("load", load[g], 1'b0);
    endtask

    // Sources in turn: sw, watchdog, osc stop, low supply, pin
    initial
    begin
        bit hit;
        void'($urandom(32'hc04b));
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        fork settle(0, 1); settle(1, 1); join
        for (int s = 0; s < 5; s++)
        begin
            hit = (s < 2) || (s == 4);
            for (int k = 0; k < 4; k++)
            begin
                @(posedge clk_sys);
                v[k] = 8'($urandom);
                we <= 4'h1 << k;
                wd <= v[k];
            end
            @(posedge clk_sys);
            we <= 4'h0;
            sw <= s == 0;
            wdt <= s == 1;
            oscs <= s == 2;
            lowv <= s == 3;
            pin_n <= s != 4;
            repeat (3) @(posedge clk_sys);
            {sw, wdt, oscs, lowv, pin_n} <= 5'h01;
            repeat (4) @(posedge clk_sys);
            chk("rst", crst, {hit, 1'b1});
            fork settle(0, 1); settle(1, hit); join
            chk("cause", cs[0], cexp[s]);
            chk("cause1", cs[1], hit ? cexp[s] : cexp[1]);
            chk("vd", {va[0], vb[0]}, s < 3 ? {v[1], v[2]} : 16'h0);
            chk("vda1", va[1], kept(!hit, v[1]));
            chk("vdb1", vb[1], kept(!hit, v[2]));
            chk("pm", pm[1], kept(s != 4, v[0]));
            chk("pm0", pm[0], kept(1'b0, v[0]));
            chk("osc", oc[0], kept(s == 2, v[3]) & 8'h83);
            chk("osc1", oc[1], kept(!hit, v[3]));
        end
        // Power-on reset in mid-run clears even what soft resets keep
        @(posedge clk_sys);
        v[0] = 8'($urandom);
        we <= 4'h1;
        wd <= v[0];
        @(posedge clk_sys);
        we <= 4'h0;
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        fork settle(0, 1); settle(1, 1); join
        chk("pm_por", pm[1], 8'h00);
        chk("cause_por", cs[0], 5'h00);
        close_out;
    end
endmodule // rscd_top_bench
